// >>> logic/burst_sram_defines.svh
// burst sram port: constants for address, data, burst timing
// assumes inclusion by the package, the port model and the bench files
`ifndef BURST_SRAM_DEFINES_SVH
`define BURST_SRAM_DEFINES_SVH
`define ADDR_WIDTH      15
`define DATA_WIDTH      32
`define WORD_COUNT      32768
`define LANE_COUNT      4
`define LANE_WIDTH      8
`define READ_LATENCY    3
`define FIFO_DEPTH      8
`define MAIN_SEL_RESET  1'b0
`endif

// >>> logic/burst_sram_pkg.sv
// burst sram port: shared types
// assumes the defines header is on the include path
`include "burst_sram_defines.svh"
package burst_sram_pkg;
    // kind of cycle taken at a clock edge
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_READ,
        CYC_WRITE
    } cycle_kind_t;
endpackage : burst_sram_pkg

// >>> logic/data_fifo.sv
// data_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module data_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    // =====================================================
    // pointer and count update
    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = (AW+1)'(cnt_reg + push - pop);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH)); // honest full
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
endmodule : data_fifo

// >>> logic/sync_burst_sram_port.sv
// sync_burst_sram_port: pin-level model of a pipelined burst sram
// assumes all synchronous pins are stable at the rising CLK_SYS edge
`timescale 1ns/1ps
`include "burst_sram_defines.svh"
module sync_burst_sram_port
    import burst_sram_pkg::*;
(
    input  wire logic                   CLK_SYS,
    input  wire logic                   ARST_N,
    input  wire logic [`ADDR_WIDTH-1:0] ADDRESS_LINES,
    input  wire logic [`DATA_WIDTH-1:0] DATA_LINES_IN,
    output logic      [`DATA_WIDTH-1:0] DATA_LINES_OUT,
    output logic                        DATA_LINES_OE,
    input  wire logic                   MAIN_SELECT_N,
    input  wire logic                   EXTRA_SELECT_LOW_N,
    input  wire logic                   EXTRA_SELECT_HIGH,
    input  wire logic                   PROC_ADDR_STROBE_N,
    input  wire logic                   CTRL_ADDR_STROBE_N,
    input  wire logic                   BURST_ADVANCE_N,
    input  wire logic                   BYTE_WRITE_GATE_N,
    input  wire logic                   LANE0_WRITE_N,
    input  wire logic                   LANE1_WRITE_N,
    input  wire logic                   LANE2_WRITE_N,
    input  wire logic                   LANE3_WRITE_N,
    input  wire logic                   GLOBAL_WRITE_N,
    input  wire logic                   OUTPUT_DRIVE_N,
    input  wire logic                   BURST_ORDER,
    input  wire logic                   SNOOZE_REQUEST
);
    // =====================================================
    // input capture registers
    logic [`ADDR_WIDTH-1:0] adr_reg;
    logic [`DATA_WIDTH-1:0] din_reg;
    logic                   sel_n_reg, xlo_n_reg, xhi_reg;
    logic                   ps_n_reg, cs_n_reg, adv_n_reg;
    logic                   gate_n_reg, gw_n_reg;
    logic [`LANE_COUNT-1:0] lane_n_reg;

    // every synchronous pin lands in a flop before use
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            adr_reg    <= '0;
            din_reg    <= '0;
            sel_n_reg  <= 1'b1;
            xlo_n_reg  <= 1'b1;
            xhi_reg    <= 1'b0;
            ps_n_reg   <= 1'b1;
            cs_n_reg   <= 1'b1;
            adv_n_reg  <= 1'b1;
            gate_n_reg <= 1'b1;
            gw_n_reg   <= 1'b1;
            lane_n_reg <= 4'hF;
        end else begin
            adr_reg    <= ADDRESS_LINES;
            din_reg    <= DATA_LINES_IN;
            sel_n_reg  <= MAIN_SELECT_N;
            xlo_n_reg  <= EXTRA_SELECT_LOW_N;
            xhi_reg    <= EXTRA_SELECT_HIGH;
            ps_n_reg   <= PROC_ADDR_STROBE_N;
            cs_n_reg   <= CTRL_ADDR_STROBE_N;
            adv_n_reg  <= BURST_ADVANCE_N;
            gate_n_reg <= BYTE_WRITE_GATE_N;
            gw_n_reg   <= GLOBAL_WRITE_N;
            lane_n_reg <= {LANE3_WRITE_N, LANE2_WRITE_N,
                           LANE1_WRITE_N, LANE0_WRITE_N};
        end
    end

    // =====================================================
    // decode of the captured controls
    // next low address bits for a burst step
    function automatic logic [1:0] burst_bits(input logic [1:0] start,
                                              input logic [1:0] count,
                                              input logic       ilv);
        if (ilv) begin
            burst_bits = start ^ count;
        end else begin
            burst_bits = 2'(start + count);
        end
    endfunction : burst_bits

    logic       all_sel, proc_load, ctrl_load, load;
    logic [3:0] lane_en;
    logic       wr_req;

    always_comb begin
        all_sel   = !sel_n_reg && !xlo_n_reg && xhi_reg;
        proc_load = !ps_n_reg && !sel_n_reg;
        // proc strobe is void with main select high, ctrl strobe acts
        ctrl_load = !cs_n_reg && !proc_load;
        load      = proc_load || ctrl_load;
        // lanes need the gate; global write forces all
        lane_en   = gate_n_reg ? 4'h0 : ~lane_n_reg;
        if (!gw_n_reg) begin
            lane_en = 4'hF;
        end
        wr_req    = (lane_en != 4'h0);
    end

    // =====================================================
    // burst state: base address, counter, selection
    logic [`ADDR_WIDTH-1:0] base_reg, base_next;
    logic [1:0]             cnt_reg, cnt_next;
    logic                   act_reg, act_next;
    logic                   ilv_reg, ilv_next;
    cycle_kind_t            kind;

    always_comb begin
        base_next = base_reg;
        cnt_next  = cnt_reg;
        act_next  = act_reg;
        ilv_next  = ilv_reg;
        kind      = CYC_IDLE;
        if (load) begin
            base_next = adr_reg;
            cnt_next  = 2'h0;
            act_next  = all_sel;
            ilv_next  = BURST_ORDER; // static, direct from pin
            if (all_sel) begin
                // proc strobe always reads, ctrl strobe as controls say
                kind = (proc_load || !wr_req) ? CYC_READ
                                               : CYC_WRITE;
            end
        end else if (act_reg) begin
            if (!adv_n_reg) begin
                cnt_next = 2'(cnt_reg + 1'b1);
            end // else wait cycle holds
            kind = wr_req ? CYC_WRITE : CYC_READ;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            base_reg <= '0;
            cnt_reg  <= 2'h0;
            act_reg  <= `MAIN_SEL_RESET;
            ilv_reg  <= 1'b1;
        end else begin
            base_reg <= base_next;
            cnt_reg  <= cnt_next;
            act_reg  <= act_next;
            ilv_reg  <= ilv_next;
        end
    end

    // access address: counter drives the two low bits
    logic [`ADDR_WIDTH-1:0] acc_adr;
    logic [1:0]             step;
    always_comb begin
        step    = load ? 2'h0 : cnt_next;
        acc_adr = {base_next[`ADDR_WIDTH-1:2],
                   burst_bits(base_next[1:0], step, ilv_next)};
    end

    // =====================================================
    // array with self-timed byte-lane write
    logic [`DATA_WIDTH-1:0] mem [`WORD_COUNT];
    logic                   do_wr;
    assign do_wr = (kind == CYC_WRITE) && !SNOOZE_REQUEST;

    always_ff @(posedge CLK_SYS) begin
        if (do_wr) begin
            for (int i = 0; i < `LANE_COUNT; i++) begin
                if (lane_en[i]) begin
                    mem[acc_adr][i*`LANE_WIDTH +: `LANE_WIDTH] <=
                        din_reg[i*`LANE_WIDTH +: `LANE_WIDTH];
                end
            end
        end
    end

    // =====================================================
    // read pipeline: word fetched, then held one stage
    logic                   rd_v_reg, rd_v_next;
    logic [`DATA_WIDTH-1:0] rd_d_reg, rd_d_next;
    logic                   is_rd;

    always_comb begin
        is_rd     = (kind == CYC_READ) && !SNOOZE_REQUEST;
        rd_v_next = is_rd;
        // array read happens after last edge's write, so pass-through
        rd_d_next = mem[acc_adr];
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_v_reg <= 1'b0;
            rd_d_reg <= '0;
        end else begin
            rd_v_reg <= rd_v_next;
            rd_d_reg <= rd_d_next;
        end
    end

    // =====================================================
    // output stage through the fifo, pin register last
    logic                   f_valid, f_ready_in;
    logic [`DATA_WIDTH-1:0] f_data;
    logic                   q_v_reg, q_v_next;
    logic [`DATA_WIDTH-1:0] q_d_reg, q_d_next;
    logic                   drv_ok;

    data_fifo #(
        .WIDTH (`DATA_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .arst_n    (ARST_N),
        .in_valid  (rd_v_reg),
        .in_ready  (f_ready_in),
        .in_data   (rd_d_reg),
        .out_valid (f_valid),
        .out_ready (1'b1),
        .out_data  (f_data)
    );

    // pops every cycle, fifo adds no latency beyond one stage
    always_comb begin
        q_v_next = f_valid && act_next; // deselect drops data
        q_d_next = f_valid ? f_data : q_d_reg;
        drv_ok   = !(lane_en != 4'h0 && !gate_n_reg);
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            q_v_reg <= 1'b0;
            q_d_reg <= '0;
        end else begin
            q_v_reg <= q_v_next; // word on pins 3 clocks in
            q_d_reg <= q_d_next;
        end
    end

    assign DATA_LINES_OUT = q_d_reg;
    // enable is combinational on the drive pin
    assign DATA_LINES_OE  = q_v_reg && drv_ok && !OUTPUT_DRIVE_N
                            && !SNOOZE_REQUEST && f_ready_in;

    // =====================================================
    // checks
    sequence s_proc_read;
        !PROC_ADDR_STROBE_N && !MAIN_SELECT_N && !EXTRA_SELECT_LOW_N
        && EXTRA_SELECT_HIGH;
    endsequence

    a_proc_read_kind: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        s_proc_read |=> kind != CYC_WRITE)
        else $error("proc strobe started a write");
    a_global_all: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !gw_n_reg |-> lane_en == 4'hF)
        else $error("global write not all lanes");
    a_gate_block: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (gate_n_reg && gw_n_reg) |-> kind != CYC_WRITE)
        else $error("write without gate");
    a_wait_holds: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (act_reg && !load && adv_n_reg) |=> $stable(cnt_reg))
        else $error("counter moved in wait");
    a_advance_step: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (act_reg && !load && !adv_n_reg)
        |=> cnt_reg == 2'($past(cnt_reg) + 1'b1))
        else $error("counter did not advance");
    a_no_load_base: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !load |=> $stable(base_reg))
        else $error("base moved without strobe");
    a_lane_hiz: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (lane_n_reg != 4'hF && !gate_n_reg) |-> !DATA_LINES_OE)
        else $error("pins driven during lane write");
    // word reaches the pin register after three more selected edges
    a_read_latency: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (is_rd && act_next) ##1 act_reg [*3] |-> q_v_reg)
        else $error("read word late");
    a_deselect_off: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (load && !all_sel) |=> !DATA_LINES_OE)
        else $error("outputs held after deselect");
    a_oe_async: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        OUTPUT_DRIVE_N |-> !DATA_LINES_OE)
        else $error("driving with enable high");
    // ctrl strobe deselects even while a voided proc strobe is low
    a_ctrl_desel: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        (!cs_n_reg && sel_n_reg) |=> !act_reg)
        else $error("ctrl strobe failed to deselect");
endmodule : sync_burst_sram_port

// >>> tb/bus_master_model.sv
// bus_master_model: far-side controller that drives the sram port pins
// assumes the bench calls put once per clock and set_pins for async pins
`timescale 1ns/1ps
`include "burst_sram_defines.svh"
module bus_master_model (
    input  wire logic                   clk,
    output logic      [`ADDR_WIDTH-1:0] a,
    output logic      [`DATA_WIDTH-1:0] din,
    output logic                        ms_n,
    output logic                        xl_n,
    output logic                        xh,
    output logic                        ps_n,
    output logic                        cs_n,
    output logic                        adv_n,
    output logic                        gate_n,
    output logic      [3:0]             lane_n,
    output logic                        gw_n,
    output logic                        od_n,
    output logic                        ord,
    output logic                        zz
);
    // ==========================================================
    // pins idle and unselected from time zero
    initial begin
        a = 15'h0000;
        din = 32'h00000000;
        {ms_n, xl_n, xh} = 3'h6;
        {ps_n, cs_n, adv_n, gate_n, gw_n} = 5'h1F;
        lane_n = 4'hF;
        {od_n, ord, zz} = 3'h0;
    end

    // ==========================================================
    // one bus cycle: every synchronous pin changes just after the edge
    task automatic put(input logic [`ADDR_WIDTH-1:0] ad,
                       input logic [2:0]             sel,
                       input logic [1:0]             strobe_n,
                       input logic                   adv,
                       input logic                   gate,
                       input logic [3:0]             lanes,
                       input logic                   gw,
                       input logic [`DATA_WIDTH-1:0] d);
        logic wr;
        wr = !gw || (!gate && lanes != 4'hF);
        @(posedge clk);
        a <= ad;
        {ms_n, xl_n, xh} <= sel;
        {ps_n, cs_n} <= strobe_n;
        adv_n <= adv;
        gate_n <= gate;
        lane_n <= lanes;
        gw_n <= gw;
        // data only in writes; otherwise a pattern that flips each cycle
        din <= wr ? d : ~din;
    endtask : put

    // asynchronous pins change at once, off the clock
    task automatic set_pins(input logic oe_n, input logic order,
                            input logic snooze);
        od_n = oe_n;
        ord = order;
        zz = snooze;
    endtask : set_pins
endmodule : bus_master_model

// >>> tb/tb.sv
// tb: self-checking bench for the burst sram port
// assumes the far side is bus_master_model and fixed 3-1-1-1 timing
`timescale 1ns/1ps
`include "burst_sram_defines.svh"
module tb;
    localparam logic [2:0] SEL_ON = 3'h1;
    logic                   clk = 1'b0;
    logic                   arst_n = 1'b0;
    logic [`ADDR_WIDTH-1:0] a;
    logic [`DATA_WIDTH-1:0] din, dout;
    logic                   oe, ms_n, xl_n, xh, ps_n, cs_n, adv_n;
    logic                   gate_n, gw_n, od_n, ord, zz;
    logic [3:0]             lane_n;
    logic [`DATA_WIDTH-1:0] exp_q [4];
    int                     n_errors = 0;
    int                     n_checks = 0;

    // ==========================================================
    // clock and instances
    always #4 clk = ~clk;

    sync_burst_sram_port u_dut (.CLK_SYS(clk), .ARST_N(arst_n),
        .ADDRESS_LINES(a), .DATA_LINES_IN(din), .DATA_LINES_OUT(dout),
        .DATA_LINES_OE(oe), .MAIN_SELECT_N(ms_n),
        .EXTRA_SELECT_LOW_N(xl_n), .EXTRA_SELECT_HIGH(xh),
        .PROC_ADDR_STROBE_N(ps_n), .CTRL_ADDR_STROBE_N(cs_n),
        .BURST_ADVANCE_N(adv_n), .BYTE_WRITE_GATE_N(gate_n),
        .LANE0_WRITE_N(lane_n[0]), .LANE1_WRITE_N(lane_n[1]),
        .LANE2_WRITE_N(lane_n[2]), .LANE3_WRITE_N(lane_n[3]),
        .GLOBAL_WRITE_N(gw_n), .OUTPUT_DRIVE_N(od_n),
        .BURST_ORDER(ord), .SNOOZE_REQUEST(zz));

    bus_master_model u_host (.clk(clk), .a(a), .din(din), .ms_n(ms_n),
        .xl_n(xl_n), .xh(xh), .ps_n(ps_n), .cs_n(cs_n), .adv_n(adv_n),
        .gate_n(gate_n), .lane_n(lane_n), .gw_n(gw_n), .od_n(od_n),
        .ord(ord), .zz(zz));

    // ==========================================================
    // compare, bus cycles and expected burst words
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [14:0] ad, input logic [31:0] d,
                      input logic gw, input logic gate, input logic [3:0] ln);
        u_host.put(ad, SEL_ON, 2'h2, 1'b1, gate, ln, gw, d);
    endtask : wr

    task automatic rd(input logic [14:0] ad);
        u_host.put(ad, SEL_ON, 2'h1, 1'b1, 1'b1, 4'hF, 1'b1, 32'h0);
    endtask : rd

    task automatic cont(input logic adv);
        u_host.put(15'h0000, SEL_ON, 2'h3, adv, 1'b1, 4'hF, 1'b1, 32'h0);
    endtask : cont

    task automatic idle();
        u_host.put(15'h0000, 3'h6, 2'h3, 1'b0, 1'b1, 4'hF, 1'b1, 32'h0);
    endtask : idle

    task automatic desel();
        // both strobes low with main select high: ctrl strobe deselects
        u_host.put(15'h0000, 3'h6, 2'h0, 1'b1, 1'b1, 4'hF, 1'b1,
                   32'h0);
        idle();
        idle();
        #1;
        chk({31'h0, oe}, 32'h0);
    endtask : desel

    function automatic logic [31:0] word_at(input logic [1:0] st,
                                            input logic [1:0] c,
                                            input logic il);
        return 32'hB0000000 | {30'h0, il ? (st ^ c) : (st + c)};
    endfunction : word_at

    // read from st, wait cycle at continuation hold, check cnt words
    task automatic burst(input logic [14:0] st, input int hold, input int cnt);
        rd(st);
        for (int n = 1; n <= 3 + cnt; n++) begin
            cont(n == hold);
            #1;
            if (n >= 4) begin
                chk({31'h0, oe}, 32'h1);
                chk(dout, exp_q[n-4]);
            end
        end
        desel();
    endtask : burst

    // ==========================================================
    // scenarios
    task automatic t_pass();
        wr(15'h0200, 32'h12345678, 1'b0, 1'b0, 4'hA);
        exp_q[0] = 32'h12345678;
        burst(15'h0200, 0, 1);
    endtask : t_pass

    task automatic t_lanes();
        logic [31:0] e;
        e = 32'h11223344;
        wr(15'h0300, e, 1'b0, 1'b1, 4'hF);
        for (int i = 0; i < 4; i++) begin
            wr(15'h0300, 32'hA3A2A1A0, 1'b1, 1'b0,
               ~(4'h1 << i[1:0]));
            e[8*i +: 8] = 8'hA0 + i[7:0];
            exp_q[0] = e;
            burst(15'h0300, 0, 1);
        end
        wr(15'h0300, 32'h55555555, 1'b1, 1'b1, 4'h0);
        wr(15'h0300, 32'h66666666, 1'b1, 1'b0, 4'hF);
        burst(15'h0300, 0, 1);
    endtask : t_lanes

    task automatic t_burst();
        for (int i = 0; i < 4; i++) begin
            wr(15'h0100 + i[14:0], word_at(2'h0, i[1:0], 1'b0),
               1'b0, 1'b1, 4'hF);
        end
        for (int o = 0; o < 2; o++) begin
            u_host.set_pins(1'b0, o[0], 1'b0);
            for (int s = 0; s < 4; s++) begin
                for (int c = 0; c < 4; c++) begin
                    exp_q[c] = word_at(s[1:0], c[1:0], o[0]);
                end
                burst(15'h0100 + s[14:0], 0, 4);
            end
        end
        // wait cycle inside an interleaved burst repeats the second word
        exp_q = '{word_at(2'h1, 2'h0, 1'b1), word_at(2'h1, 2'h1, 1'b1),
                  word_at(2'h1, 2'h1, 1'b1), word_at(2'h1, 2'h2, 1'b1)};
        burst(15'h0101, 2, 4);
        u_host.set_pins(1'b0, 1'b0, 1'b0);
    endtask : t_burst

    task automatic t_sel();
        logic [3:0] bad [4];
        bad = '{4'h5, 4'hB, 4'h8, 4'h0};
        for (int i = 0; i < 4; i++) begin
            u_host.put(15'h0100, bad[i][2:0], {bad[i][3], !bad[i][3]},
                       1'b0, 1'b1, 4'hF, 1'b1, 32'h0);
            repeat (5) begin
                idle();
                #1;
                chk({31'h0, oe}, 32'h0);
            end
        end
    endtask : t_sel

    task automatic t_async();
        u_host.set_pins(1'b1, 1'b0, 1'b0);
        rd(15'h0102);
        repeat (4) cont(1'b1);
        #1;
        chk({31'h0, oe}, 32'h0);
        u_host.set_pins(1'b0, 1'b0, 1'b0);
        #1;
        chk({31'h0, oe}, 32'h1);
        chk(dout, 32'hB0000002);
        // snooze drops the drivers at once, off the clock
        u_host.set_pins(1'b0, 1'b0, 1'b1);
        #1;
        chk({31'h0, oe}, 32'h0);
        u_host.set_pins(1'b0, 1'b0, 1'b0);
        #1;
        chk({31'h0, oe}, 32'h1);
        desel();
    endtask : t_async

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // hang guard and main sequence
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1;
        chk({31'h0, oe}, 32'h0);
        chk(dout, 32'h0);
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_pass();
        t_lanes();
        t_burst();
        t_sel();
        t_async();
        tally_and_finish();
    end
endmodule : tb
